// ===== src/smpc_pkg.sv
// Constants, types and register map of the stop mode power controller
package smpc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIN_W  = 8;

  // Register offsets
  localparam logic [7:0] OFS_PWR_MODE = 8'h00;
  localparam logic [7:0] OFS_DBG_CTL  = 8'h01;
  localparam logic [7:0] OFS_LVD_CTL  = 8'h02;
  localparam logic [7:0] OFS_CLK_CFG  = 8'h03;
  localparam logic [7:0] OFS_STATUS   = 8'h04;

  // power_mode_control_reg fields
  localparam int unsigned PM_SEL_BIT    = 0;
  localparam int unsigned PM_PERMIT_BIT = 1;
  localparam int unsigned PM_WAKEF_BIT  = 2;
  localparam int unsigned PM_ACK_BIT    = 3;
  // debug_status_control_reg fields
  localparam int unsigned DBG_PERMIT_BIT = 0;
  localparam int unsigned DBG_ACTIVE_BIT = 1;
  // Low voltage control fields
  localparam int unsigned LV_ON_BIT    = 0;
  localparam int unsigned LV_STOP_BIT  = 1;
  localparam int unsigned LV_RSEL_BIT  = 2;
  localparam int unsigned LV_FLAG_BIT  = 3;
  localparam int unsigned LV_LEVEL_BIT = 4;
  // Clock config fields
  localparam int unsigned CK_OSC_BIT   = 0;
  localparam int unsigned CK_ASYNC_BIT = 1;
  // Status fields
  localparam int unsigned ST_MODE_LSB = 0;
  localparam int unsigned ST_HOLD_BIT = 3;

  // Reset values
  localparam logic RST_PD_SEL      = 1'b0;
  localparam logic RST_STOP_PERMIT = 1'b0;
  localparam logic RST_DBG_PERMIT  = 1'b0;
  localparam logic RST_LV_ON       = 1'b0;
  localparam logic RST_LV_STOP     = 1'b0;
  localparam logic RST_LV_RSEL     = 1'b0;
  localparam logic RST_OSC_KEEP    = 1'b0;
  localparam logic RST_ASYNC_CLK   = 1'b0;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SHALLOW,
    ST_DEEP,
    ST_DEEP_WAKE,
    ST_BGND
  } smpc_state_e;

  // Power and clock controls toward the rest of the chip
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic dbg_clk_en;
    logic regulator_full;
    logic clkgen_standby;
    logic clkgen_off;
    logic osc_run;
    logic clkgen_reset;
    logic periph_reset;
    logic adc_standby;
    logic adc_run_in_stop;
    logic adc_reset;
    logic keypad_wake_en;
    logic keypad_reset;
    logic core_reset;
  } smpc_pwr_ctl_s;

  // Wake sources
  typedef struct packed {
    logic wakeup_timer;
    logic adc;
    logic keypad;
    logic serial;
  } smpc_wake_s;
endpackage

// ===== src/smpc_sync2.sv
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module smpc_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ===== src/smpc_pinhold.sv
// Pin state latch that freezes pin values across deep stop
`timescale 1ns/1ps
`default_nettype none
module smpc_pinhold #(
  parameter int unsigned W = 8
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  input  wire logic         latch_in,
  input  wire logic         release_in,
  input  wire logic [W-1:0] live_in,
  output logic      [W-1:0] pin_out,
  output logic              hold_out
);
  logic [W-1:0] held_ff;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_out <= 1'b0;
    end else if (latch_in) begin
      hold_out <= 1'b1;
    end else if (release_in) begin
      hold_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      held_ff <= '0;
    end else if (latch_in && !hold_out) begin
      held_ff <= live_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out <= '0;
    end else begin
      pin_out <= hold_out ? held_ff : live_in;
    end
  end
endmodule
`default_nettype wire

// ===== src/smpc_ctrl.sv
// Stop mode power controller: mode choice, power controls, debug, pins
// How it works
// [R01] Background entry from run only when debug_entry_permit is set.
// [R02] Debug clock kept running in stop if permit set at entry.
// [R03] Regulator stays at full regulation in stop while debug permitted.
// [R04] Deep stop request with debug permit set becomes shallow stop.
// [R05] Status memory commands in stop give stop/wait error, no access.
// [R06] Background command in stop with permit wakes into background.
// [R07] In background state every debug command is accepted.
// [R08] Low supply raises an interrupt flag or a reset pulse.
// [R09] Both low-voltage enables set keep regulator active in stop.
// [R10] Deep stop request with low-voltage stop detect becomes shallow.
// [R11] All peripheral clocks gated in any stop, even with debug.
// [R12] Shallow stop keeps pins, RAM and register contents.
// [R13] Pins are latched before deep stop is entered.
// [R14] Deep wake resets registers, keeps pins latched until ack.
// [R15] Shallow stop: clock generator standby, oscillator per keep bit; with debug permit at entry both keep running.
// [R16] Deep stop: clock generator off, oscillator off, reset on wake.
// [R17] Timer, serial, SPI, I2C halted in stop, reset after deep wake.
// [R18] Converter standby in stop unless async clock in shallow stop; reset after deep.
// [R19] Keypad wakes shallow stop; disabled and reset in deep stop.
// [R20] Stop without stop_permit forces an illegal opcode reset.
// [R21] powerdown_select one picks deep stop, zero picks shallow.
// [R22] Ack write releases pins; wake flag stays set until then.
// [R23] Shallow stop exits on listed interrupts or the reset pin.
// [R24] Either override forces shallow, else powerdown_select decides.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module smpc_ctrl (
  input  wire logic                       mclk_in,
  input  wire logic                       rst_n_in,
  // Register port
  input  wire logic [smpc_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [smpc_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic      [smpc_pkg::DATA_W-1:0] reg_rdata_out,
  // CPU
  input  wire logic                       stop_exec_in,
  output logic                            illegal_op_reset_out,
  // Wake sources
  input  wire logic                       ext_irq_n_in,
  input  wire logic                       wakeup_timer_irq_in,
  input  wire smpc_pkg::smpc_wake_s        wake_in,
  input  wire logic                       low_supply_in,
  output logic                            lvd_irq_out,
  output logic                            lvd_reset_out,
  // Debug host
  input  wire logic                       dbg_background_in,
  input  wire logic                       dbg_go_in,
  input  wire logic                       dbg_mem_status_in,
  output logic                            dbg_mem_err_out,
  output logic                            dbg_mem_ok_out,
  output logic                            dbg_full_access_out,
  // Power controls and pins
  output smpc_pkg::smpc_pwr_ctl_s          pwr_ctl_out,
  input  wire logic [smpc_pkg::PIN_W-1:0] pin_live_in,
  output logic      [smpc_pkg::PIN_W-1:0] pin_out,
  output logic                            pin_hold_out
);
  smpc_pkg::smpc_state_e   state_ff, nxt_state;
  smpc_pkg::smpc_pwr_ctl_s nxt_ctl;
  logic pd_sel_ff, stop_permit_ff, dbg_permit_ff, lv_on_ff, lv_stop_ff;
  logic lv_rsel_ff, lv_flag_ff, osc_keep_ff, async_clk_ff, wake_flag_ff;
  logic stop_dbg_ff, low_prev_ff, irq_n_s, rti_s, low_s;
  logic wr_pm, wr_dbg, wr_lv, wr_ck, ack_wr, stopped, lv_in_stop, go_deep;
  logic stop_ok, stop_bad, shallow_wake, deep_wake, bg_wake, lv_active;
  logic lv_event, deep_reset;

  // External pins are synchronised before use
  smpc_sync2 #(
    .W(3)
  ) u_sync (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .async_in ({ext_irq_n_in, wakeup_timer_irq_in, low_supply_in}),
    .sync_out ({irq_n_s, rti_s, low_s})
  );

  assign wr_pm  = reg_wr_in && (reg_addr_in == smpc_pkg::OFS_PWR_MODE);
  assign wr_dbg = reg_wr_in && (reg_addr_in == smpc_pkg::OFS_DBG_CTL);
  assign wr_lv  = reg_wr_in && (reg_addr_in == smpc_pkg::OFS_LVD_CTL);
  assign wr_ck  = reg_wr_in && (reg_addr_in == smpc_pkg::OFS_CLK_CFG);
  assign ack_wr = wr_pm && reg_wdata_in[smpc_pkg::PM_ACK_BIT];

  assign stopped    = (state_ff == smpc_pkg::ST_SHALLOW) ||
                      (state_ff == smpc_pkg::ST_DEEP);
  assign lv_in_stop = lv_on_ff && lv_stop_ff;
  assign deep_reset = (state_ff == smpc_pkg::ST_DEEP_WAKE);

  // Final mode choice
  assign go_deep  = pd_sel_ff &&        // [R21]
                    !dbg_permit_ff &&   // [R04]
                    !lv_in_stop;        // [R10] [R24]
  assign stop_ok  = (state_ff == smpc_pkg::ST_RUN) && stop_exec_in &&
                    stop_permit_ff;
  assign stop_bad = (state_ff == smpc_pkg::ST_RUN) && stop_exec_in &&
                    !stop_permit_ff;    // [R20]

  // Shallow stop exits on any enabled interrupt source
  assign shallow_wake = !irq_n_s || rti_s || wake_in.adc ||
                        wake_in.keypad || wake_in.serial ||
                        lvd_irq_out;    // [R23] [R19]
  // Deep stop wakes only from the external pin or the wakeup timer
  assign deep_wake = !irq_n_s || rti_s;
  assign bg_wake   = dbg_background_in && dbg_permit_ff;  // [R06]

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      smpc_pkg::ST_RUN: begin
        if (stop_ok) begin
          nxt_state = go_deep ? smpc_pkg::ST_DEEP
                              : smpc_pkg::ST_SHALLOW;  // [R24]
        end else if (bg_wake) begin
          nxt_state = smpc_pkg::ST_BGND;  // [R01]
        end
      end
      smpc_pkg::ST_SHALLOW: begin
        if (bg_wake && stop_dbg_ff) begin
          nxt_state = smpc_pkg::ST_BGND;  // [R06]
        end else if (shallow_wake) begin
          nxt_state = smpc_pkg::ST_RUN;   // [R23]
        end
      end
      smpc_pkg::ST_DEEP: begin
        if (deep_wake) begin
          nxt_state = smpc_pkg::ST_DEEP_WAKE;
        end
      end
      smpc_pkg::ST_DEEP_WAKE: begin
        nxt_state = smpc_pkg::ST_RUN;
      end
      smpc_pkg::ST_BGND: begin
        if (dbg_go_in) begin
          nxt_state = smpc_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_state = smpc_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= smpc_pkg::ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Debug permit as seen when the stop was taken
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stop_dbg_ff <= 1'b0;
    end else if (stop_ok) begin
      stop_dbg_ff <= dbg_permit_ff;  // [R02]
    end
  end

  // Control registers; a deep wake returns them to reset values
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pd_sel_ff      <= smpc_pkg::RST_PD_SEL;
      stop_permit_ff <= smpc_pkg::RST_STOP_PERMIT;
    end else if (deep_reset) begin
      pd_sel_ff      <= smpc_pkg::RST_PD_SEL;       // [R14]
      stop_permit_ff <= smpc_pkg::RST_STOP_PERMIT;
    end else if (wr_pm) begin
      pd_sel_ff      <= reg_wdata_in[smpc_pkg::PM_SEL_BIT];
      stop_permit_ff <= reg_wdata_in[smpc_pkg::PM_PERMIT_BIT];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dbg_permit_ff <= smpc_pkg::RST_DBG_PERMIT;
    end else if (deep_reset) begin
      dbg_permit_ff <= smpc_pkg::RST_DBG_PERMIT;
    end else if (wr_dbg) begin
      dbg_permit_ff <= reg_wdata_in[smpc_pkg::DBG_PERMIT_BIT];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lv_on_ff   <= smpc_pkg::RST_LV_ON;
      lv_stop_ff <= smpc_pkg::RST_LV_STOP;
      lv_rsel_ff <= smpc_pkg::RST_LV_RSEL;
    end else if (deep_reset) begin
      lv_on_ff   <= smpc_pkg::RST_LV_ON;
      lv_stop_ff <= smpc_pkg::RST_LV_STOP;
      lv_rsel_ff <= smpc_pkg::RST_LV_RSEL;
    end else if (wr_lv) begin
      lv_on_ff   <= reg_wdata_in[smpc_pkg::LV_ON_BIT];
      lv_stop_ff <= reg_wdata_in[smpc_pkg::LV_STOP_BIT];
      lv_rsel_ff <= reg_wdata_in[smpc_pkg::LV_RSEL_BIT];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_keep_ff  <= smpc_pkg::RST_OSC_KEEP;
      async_clk_ff <= smpc_pkg::RST_ASYNC_CLK;
    end else if (deep_reset) begin
      osc_keep_ff  <= smpc_pkg::RST_OSC_KEEP;
      async_clk_ff <= smpc_pkg::RST_ASYNC_CLK;
    end else if (wr_ck) begin
      osc_keep_ff  <= reg_wdata_in[smpc_pkg::CK_OSC_BIT];
      async_clk_ff <= reg_wdata_in[smpc_pkg::CK_ASYNC_BIT];
    end
  end

  // Deep wake flag: set on wake, held until the ack write; set wins
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_flag_ff <= 1'b0;
    end else if (deep_reset) begin
      wake_flag_ff <= 1'b1;   // [R22]
    end else if (ack_wr) begin
      wake_flag_ff <= 1'b0;   // [R22]
    end
  end

  // Low voltage detection, active in run and in stop when enabled
  assign lv_active = lv_on_ff && (!stopped || lv_stop_ff);
  assign lv_event  = lv_active && low_s && !low_prev_ff;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_prev_ff <= 1'b0;
    end else begin
      low_prev_ff <= low_s;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lv_flag_ff <= 1'b0;
    end else if (lv_event && !lv_rsel_ff) begin
      lv_flag_ff <= 1'b1;     // [R08]
    end else if (wr_lv && reg_wdata_in[smpc_pkg::LV_FLAG_BIT]) begin
      lv_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lvd_irq_out          <= 1'b0;
      lvd_reset_out        <= 1'b0;
      illegal_op_reset_out <= 1'b0;
    end else begin
      lvd_irq_out          <= lv_flag_ff;
      lvd_reset_out        <= lv_event && lv_rsel_ff;  // [R08]
      illegal_op_reset_out <= stop_bad;                // [R20]
    end
  end

  // Debug command answers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dbg_mem_err_out     <= 1'b0;
      dbg_mem_ok_out      <= 1'b0;
      dbg_full_access_out <= 1'b0;
    end else begin
      dbg_mem_err_out     <= dbg_mem_status_in && stopped;   // [R05]
      dbg_mem_ok_out      <= dbg_mem_status_in && !stopped;
      dbg_full_access_out <= (nxt_state == smpc_pkg::ST_BGND); // [R07]
    end
  end

  // Power and clock controls per state
  always_comb begin
    nxt_ctl = '0;
    nxt_ctl.cpu_clk_en    = !stopped;
    nxt_ctl.periph_clk_en = !stopped;                  // [R11] [R17]
    nxt_ctl.dbg_clk_en    = !stopped ||
                            (stop_dbg_ff && !go_deep); // [R02]
    nxt_ctl.regulator_full = !stopped || stop_dbg_ff ||  // [R03]
                             lv_in_stop;                 // [R09]
    if (state_ff == smpc_pkg::ST_SHALLOW) begin
      nxt_ctl.clkgen_standby = !stop_dbg_ff;           // [R15]
      nxt_ctl.osc_run        = osc_keep_ff || stop_dbg_ff;
    end else begin
      nxt_ctl.clkgen_standby = 1'b0;
      nxt_ctl.osc_run        = (state_ff != smpc_pkg::ST_DEEP);
    end
    nxt_ctl.clkgen_off      = (state_ff == smpc_pkg::ST_DEEP); // [R16]
    nxt_ctl.clkgen_reset    = deep_reset;              // [R16]
    nxt_ctl.periph_reset    = deep_reset;              // [R17]
    nxt_ctl.adc_run_in_stop = (state_ff == smpc_pkg::ST_SHALLOW) &&
                              async_clk_ff;            // [R18]
    nxt_ctl.adc_standby     = stopped && !nxt_ctl.adc_run_in_stop;
    nxt_ctl.adc_reset       = deep_reset;              // [R18]
    nxt_ctl.keypad_wake_en  = (state_ff == smpc_pkg::ST_SHALLOW);
    nxt_ctl.keypad_reset    = (state_ff == smpc_pkg::ST_DEEP) ||
                              deep_reset;              // [R19]
    nxt_ctl.core_reset      = deep_reset;              // [R14]
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_ctl_out <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1,
                       dbg_clk_en: 1'b1, regulator_full: 1'b1,
                       osc_run: 1'b1, default: 1'b0};
    end else begin
      pwr_ctl_out <= nxt_ctl;  // [R12]
    end
  end

  // Pins are frozen on deep entry and freed by the ack write
  smpc_pinhold #(
    .W(smpc_pkg::PIN_W)
  ) u_pinhold (
    .mclk_in    (mclk_in),
    .rst_n_in   (rst_n_in),
    .latch_in   (stop_ok && go_deep),     // [R13]
    .release_in (ack_wr && !deep_reset),  // [R14] [R22]
    .live_in    (pin_live_in),
    .pin_out    (pin_out),
    .hold_out   (pin_hold_out)
  );

  // Register read, data valid the cycle after the strobe
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= '0;
      case (reg_addr_in)
        smpc_pkg::OFS_PWR_MODE: begin
          reg_rdata_out[smpc_pkg::PM_SEL_BIT]    <= pd_sel_ff;
          reg_rdata_out[smpc_pkg::PM_PERMIT_BIT] <= stop_permit_ff;
          reg_rdata_out[smpc_pkg::PM_WAKEF_BIT]  <= wake_flag_ff;
        end
        smpc_pkg::OFS_DBG_CTL: begin
          reg_rdata_out[smpc_pkg::DBG_PERMIT_BIT] <= dbg_permit_ff;
          reg_rdata_out[smpc_pkg::DBG_ACTIVE_BIT] <=
            (state_ff == smpc_pkg::ST_BGND);
        end
        smpc_pkg::OFS_LVD_CTL: begin
          reg_rdata_out[smpc_pkg::LV_ON_BIT]    <= lv_on_ff;
          reg_rdata_out[smpc_pkg::LV_STOP_BIT]  <= lv_stop_ff;
          reg_rdata_out[smpc_pkg::LV_RSEL_BIT]  <= lv_rsel_ff;
          reg_rdata_out[smpc_pkg::LV_FLAG_BIT]  <= lv_flag_ff;
          reg_rdata_out[smpc_pkg::LV_LEVEL_BIT] <= low_s;
        end
        smpc_pkg::OFS_CLK_CFG: begin
          reg_rdata_out[smpc_pkg::CK_OSC_BIT]   <= osc_keep_ff;
          reg_rdata_out[smpc_pkg::CK_ASYNC_BIT] <= async_clk_ff;
        end
        smpc_pkg::OFS_STATUS: begin
          reg_rdata_out[smpc_pkg::ST_MODE_LSB +: 3] <= 3'(state_ff);
          reg_rdata_out[smpc_pkg::ST_HOLD_BIT]      <= pin_hold_out;
        end
        default: begin
          reg_rdata_out <= '0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== testbench/smpc_ctrl_assertions.sv
// Port level checks of the stop mode power controller
`timescale 1ns/1ps
`default_nettype none
module smpc_ctrl_assertions (
  input wire logic                       mclk_in,
  input wire logic                       rst_n_in,
  input wire logic                       stop_exec_in,
  input wire logic                       illegal_op_reset_out,
  input wire logic                       dbg_mem_status_in,
  input wire logic                       dbg_mem_err_out,
  input wire logic                       dbg_mem_ok_out,
  input wire logic                       dbg_full_access_out,
  input wire smpc_pkg::smpc_pwr_ctl_s    pwr_ctl_out,
  input wire logic [smpc_pkg::PIN_W-1:0] pin_out,
  input wire logic                       pin_hold_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_mem_one_answer: assert property (dbg_mem_status_in |=>
    (dbg_mem_err_out != dbg_mem_ok_out)) else $error("mem answer");
  a_bgnd_mem_ok: assert property (dbg_full_access_out &&
    dbg_mem_status_in |=> dbg_mem_ok_out) else $error("bgnd mem");
  a_periph_gated: assert property (!pwr_ctl_out.cpu_clk_en |->
    !pwr_ctl_out.periph_clk_en) else $error("periph clock");
  a_dbg_reg_full: assert property (pwr_ctl_out.dbg_clk_en &&
    !pwr_ctl_out.cpu_clk_en |-> pwr_ctl_out.regulator_full)
    else $error("regulator");
  a_deep_all_off: assert property (pwr_ctl_out.clkgen_off |->
    !pwr_ctl_out.osc_run && !pwr_ctl_out.regulator_full &&
    !pwr_ctl_out.dbg_clk_en && !pwr_ctl_out.keypad_wake_en)
    else $error("deep controls");
  a_wake_resets: assert property ($rose(pwr_ctl_out.clkgen_reset) |->
    pwr_ctl_out.periph_reset && pwr_ctl_out.adc_reset &&
    pwr_ctl_out.keypad_reset ##1 !pwr_ctl_out.clkgen_reset)
    else $error("wake resets");
  a_illegal_cause: assert property (illegal_op_reset_out |->
    $past(stop_exec_in) ##1 !illegal_op_reset_out) else $error("illegal");
  a_hold_at_stop: assert property ($rose(pin_hold_out) |->
    $past(stop_exec_in)) else $error("pin hold");
  a_held_pins: assert property (pin_hold_out && $past(pin_hold_out) |->
    $stable(pin_out)) else $error("held pins");
endmodule
bind smpc_ctrl smpc_ctrl_assertions u_smpc_ctrl_assertions (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .stop_exec_in(stop_exec_in),
  .illegal_op_reset_out(illegal_op_reset_out),
  .dbg_mem_status_in(dbg_mem_status_in), .dbg_mem_err_out(dbg_mem_err_out),
  .dbg_mem_ok_out(dbg_mem_ok_out), .dbg_full_access_out(dbg_full_access_out),
  .pwr_ctl_out(pwr_ctl_out), .pin_out(pin_out), .pin_hold_out(pin_hold_out));
`default_nettype wire

// ===== testbench/smpc_ctrl_tb.sv
// Self-checking bench of the stop mode power controller
`timescale 1ns/1ps
`default_nettype none
module smpc_ctrl_tb;
  logic       mclk_in, rst_n_in, reg_wr_in, reg_rd_in, stop_exec_in;
  logic       illegal_op_reset_out, ext_irq_n_in, wakeup_timer_irq_in;
  logic       low_supply_in, lvd_irq_out, lvd_reset_out, dbg_go_in;
  logic       dbg_background_in, dbg_mem_status_in, dbg_mem_err_out;
  logic       dbg_mem_ok_out, dbg_full_access_out, pin_hold_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, pin_live_in;
  logic [7:0] pin_out, rv, pins;
  logic [3:0] m;
  logic       deep, osc, asy, seen_rst;
  int         errors, compares;
  smpc_pkg::smpc_wake_s    wake_in;
  smpc_pkg::smpc_pwr_ctl_s pwr_ctl_out;
  logic [7:0] mask [4] = '{8'h03, 8'h01, 8'h07, 8'h03};

  smpc_ctrl u_smpc_ctrl (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .stop_exec_in(stop_exec_in), .illegal_op_reset_out(illegal_op_reset_out),
    .ext_irq_n_in(ext_irq_n_in), .wakeup_timer_irq_in(wakeup_timer_irq_in),
    .wake_in(wake_in), .low_supply_in(low_supply_in),
    .lvd_irq_out(lvd_irq_out), .lvd_reset_out(lvd_reset_out),
    .dbg_background_in(dbg_background_in), .dbg_go_in(dbg_go_in),
    .dbg_mem_status_in(dbg_mem_status_in), .dbg_mem_err_out(dbg_mem_err_out),
    .dbg_mem_ok_out(dbg_mem_ok_out), .dbg_full_access_out(dbg_full_access_out),
    .pwr_ctl_out(pwr_ctl_out), .pin_live_in(pin_live_in), .pin_out(pin_out),
    .pin_hold_out(pin_hold_out));

  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rc(logic [7:0] a, logic [7:0] e);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("rdata", reg_rdata_out, e);
  endtask
  // One-cycle pulse: 0 stop, 1 background, 2 go, 3 memory status
  task automatic cmd(int k);
    @(posedge mclk_in);
    stop_exec_in      <= (k == 0);
    dbg_background_in <= (k == 1);
    dbg_go_in         <= (k == 2);
    dbg_mem_status_in <= (k == 3);
    @(posedge mclk_in);
    {stop_exec_in, dbg_background_in, dbg_go_in, dbg_mem_status_in} <= 4'h0;
    #1;
  endtask
  // Bounded wait: 0 cpu clock, 1 background, 2 lvd reset, 3 lvd irq
  task automatic wait_sig(int k);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 16 && !got; i++) begin
      @(posedge mclk_in);
      #1;
      seen_rst |= pwr_ctl_out.clkgen_reset & pwr_ctl_out.periph_reset &
                  pwr_ctl_out.adc_reset & pwr_ctl_out.keypad_reset &
                  pwr_ctl_out.core_reset;
      got = (k == 0) ? pwr_ctl_out.cpu_clk_en : (k == 1) ?
            dbg_full_access_out : (k == 2) ? lvd_reset_out : lvd_irq_out;
    end
    if (got !== 1'b1) begin
      chk("timeout", 16'h0, 16'h1);
      tally_and_finish();
    end
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  initial begin
    {errors, compares} = '0;
    {rst_n_in, reg_wr_in, reg_rd_in, stop_exec_in, dbg_go_in} = '0;
    {dbg_background_in, dbg_mem_status_in, low_supply_in, seen_rst} = '0;
    {reg_addr_in, reg_wdata_in, pin_live_in} = '0;
    wakeup_timer_irq_in = 1'b0;
    ext_irq_n_in = 1'b1;
    wake_in = '0;
    void'($urandom(32'h9e5c));
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    chk("pwr_run", pwr_ctl_out, 16'h7900);
    for (int a = 0; a < 6; a++) rc(8'(a), 8'h00);
    for (int i = 0; i < 12; i++) begin
      rv = 8'($urandom) & mask[i % 4];
      wr(8'(i % 4), rv);
      rc(8'(i % 4), rv);
    end
    wr(8'h00, 8'h01);
    cmd(0);
    chk("illegal", illegal_op_reset_out, 1'b1);
    rc(8'h04, 8'h00);
    wr(8'h01, 8'h00);
    cmd(1);
    repeat (3) @(posedge mclk_in);
    #1;
    chk("bgnd_off", dbg_full_access_out, 1'b0);
    wr(8'h01, 8'h01);
    cmd(1);
    wait_sig(1);
    rc(8'h01, 8'h03);
    cmd(3);
    chk("mem_ok", dbg_mem_ok_out, 1'b1);
    cmd(2);
    wr(8'h02, 8'h05);
    low_supply_in <= 1'b1;
    wait_sig(2);
    low_supply_in <= 1'b0;
    wr(8'h02, 8'h01);
    repeat (4) @(posedge mclk_in);
    low_supply_in <= 1'b1;
    wait_sig(3);
    rc(8'h02, 8'h19);
    wr(8'h02, 8'h08);
    rc(8'h02, 8'h10);
    chk("lvd_irq", lvd_irq_out, 1'b0);
    low_supply_in <= 1'b0;
    for (int n = 0; n < 16; n++) begin
      m = 4'(n);
      osc = 1'($urandom);
      asy = 1'($urandom);
      deep = m[0] & !m[1] & !(m[2] & m[3]);
      pins = 8'($urandom);
      wr(8'h00, {6'h00, 1'b1, m[0]});
      wr(8'h01, {7'h00, m[1]});
      wr(8'h02, {6'h00, m[3], m[2]});
      wr(8'h03, {6'h00, asy, osc});
      pin_live_in <= pins;
      cmd(0);
      pin_live_in <= ~pins;
      repeat (2) @(posedge mclk_in);
      #1;
      chk("periph", pwr_ctl_out.periph_clk_en, 1'b0);
      chk("dbg_clk", pwr_ctl_out.dbg_clk_en, m[1]);
      chk("reg", pwr_ctl_out.regulator_full, m[1] | m[2] & m[3]);
      chk("ck_off", pwr_ctl_out.clkgen_off, deep);
      chk("ck_sby", pwr_ctl_out.clkgen_standby, !deep & !m[1]);
      chk("osc", pwr_ctl_out.osc_run, !deep & (osc | m[1]));
      chk("adc_run", pwr_ctl_out.adc_run_in_stop, !deep & asy);
      chk("adc_sby", pwr_ctl_out.adc_standby, deep | !asy);
      chk("kbd", pwr_ctl_out.keypad_wake_en, !deep);
      chk("hold", pin_hold_out, deep);
      rc(8'h04, deep ? 8'h0a : 8'h01);
      seen_rst = 1'b0;
      if (m[1]) begin
        cmd(3);
        chk("mem_err", dbg_mem_err_out, 1'b1);
        cmd(1);
        wait_sig(1);
        cmd(3);
        chk("mem_ok", dbg_mem_ok_out, 1'b1);
        cmd(2);
        wait_sig(0);
      end else if (deep) begin
        @(posedge mclk_in);
        ext_irq_n_in <= 1'b0;
        wait_sig(0);
        ext_irq_n_in <= 1'b1;
        chk("wake_rst", seen_rst, 1'b1);
        chk("frozen", pin_out, pins);
        rc(8'h00, 8'h04);
        chk("hold", pin_hold_out, 1'b1);
        wr(8'h00, 8'h08);
        rc(8'h00, 8'h00);
        chk("free", pin_hold_out, 1'b0);
      end else begin
        @(posedge mclk_in);
        wake_in <= smpc_pkg::smpc_wake_s'(4'h1 << $urandom_range(2, 0));
        wait_sig(0);
        wake_in <= '0;
        chk("hold", pin_hold_out, 1'b0);
      end
      repeat (4) @(posedge mclk_in);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
